/* logic/sfg_pkg.sv */
package sfg_pkg;

  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE = 8'hab;

  // ----------------------------------------------------------------
  // frame shape
  // ----------------------------------------------------------------
  localparam int unsigned BITS_PER_BYTE = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_ZERO = 3'h0;
  localparam logic [2:0] BYTES_MAX = 3'h7;
  localparam logic [2:0] BYTES_OPCODE = 3'h1;
  localparam logic [2:0] BYTES_STATUS_WRITE = 3'h2;
  localparam logic [2:0] BYTES_HEADER = 3'h4;
  localparam logic [2:0] BYTES_PROGRAM_MIN = 3'h5;

  // ----------------------------------------------------------------
  // status byte layout and reset value
  // ----------------------------------------------------------------
  localparam int unsigned SR_BUSY = 0;
  localparam int unsigned SR_WEL = 1;
  localparam int unsigned SR_BP_LO = 2;
  localparam int unsigned SR_BP_HI = 4;
  localparam int unsigned SR_TB = 5;
  localparam int unsigned SR_LOCK = 7;
  localparam logic [4:0] PROT_RESET = 5'h00;
  localparam logic LOCK_RESET = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned T_STATUS_WRITE_SLOW_MS = 10;
  localparam int unsigned T_STATUS_WRITE_FAST_MS = 15;
  localparam int unsigned T_DEEP_SLEEP_US = 3;
  localparam int unsigned T_WAKE_US = 3;
  localparam int unsigned STATUS_WRITE_SLOW_CYCLES = T_STATUS_WRITE_SLOW_MS * 1000 * CLK_MHZ;
  localparam int unsigned STATUS_WRITE_FAST_CYCLES = T_STATUS_WRITE_FAST_MS * 1000 * CLK_MHZ;
  localparam int unsigned DEEP_SLEEP_CYCLES = T_DEEP_SLEEP_US * CLK_MHZ;
  localparam int unsigned WAKE_CYCLES = T_WAKE_US * CLK_MHZ;
  localparam int unsigned TIMER_W = 21;

  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_status_write = 5'h02,
    st_enter_sleep = 5'h04,
    st_sleep = 5'h08,
    st_wake = 5'h10
  } sfg_state_t;

endpackage

/* logic/sfg_command_guard.sv */
`timescale 1ns/1ps

// Notes on behaviour
// - write command dropped unless release on byte
// - page program needs whole data bytes
// - status write takes exactly one payload byte
// - status write done within 10/15 ms
// - deep sleep reached within 3 us
// - wake from deep sleep within 3 us
// - status write ignored when locked and protected
// - deep sleep ignored while write busy
module sfg_command_guard #(
  parameter int unsigned STATUS_WRITE_SLOW = sfg_pkg::STATUS_WRITE_SLOW_CYCLES,
  parameter int unsigned STATUS_WRITE_FAST = sfg_pkg::STATUS_WRITE_FAST_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  input wire logic fast_grade,
  input wire logic array_busy,
  output logic busy,
  output logic ready,
  output logic [7:0] status_byte,
  output logic deep_sleep,
  output logic array_start,
  output logic [7:0] array_opcode,
  output logic [23:0] array_addr,
  output logic cmd_rejected
);
  import sfg_pkg::*;

  // ----------------------------------------------------------------
  // serial capture
  // ----------------------------------------------------------------
  logic sck_q;
  logic cs_n_q;
  logic [2:0] bit_cnt_q;
  logic [2:0] byte_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] opcode_q;
  logic [23:0] addr_q;
  logic [7:0] payload_q;
  logic [7:0] next_byte;
  logic sck_rise;
  logic cs_rise;
  logic cs_fall;
  logic byte_done;

  assign sck_rise = sck & ~sck_q & ~cs_n & ~cs_n_q;
  assign cs_rise = cs_n & ~cs_n_q;
  assign cs_fall = ~cs_n & cs_n_q;
  assign byte_done = sck_rise && (bit_cnt_q == BIT_LAST);
  assign next_byte = {shift_q[6:0], si};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sck_q <= sck;
      cs_n_q <= cs_n;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt_q <= BIT_ZERO;
      byte_cnt_q <= 3'h0;
      shift_q <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt_q <= BIT_ZERO;
      byte_cnt_q <= 3'h0;
      shift_q <= 8'h00;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= next_byte;
      // saturate: only "at least N" and "exactly N" matter below the cap
      if (byte_done && byte_cnt_q != BYTES_MAX) begin
        byte_cnt_q <= byte_cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
      payload_q <= 8'h00;
    end else if (byte_done) begin
      case (byte_cnt_q)
        3'h0: opcode_q <= next_byte;
        3'h1: begin
          addr_q[23:16] <= next_byte;
          payload_q <= next_byte;
        end
        3'h2: addr_q[15:8] <= next_byte;
        3'h3: addr_q[7:0] <= next_byte;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // frame qualification at release
  // ----------------------------------------------------------------
  sfg_state_t state_q;
  logic wel_q;
  logic [3:0] prot_q;
  logic lock_q;
  logic [TIMER_W-1:0] timer_q;
  logic aligned;
  logic have_op;
  logic is_erase;
  logic write_busy;
  logic asleep;
  logic locked;
  logic acc_status_write;
  logic acc_program;
  logic acc_erase;
  logic acc_enter_sleep;
  logic acc_wake;
  logic acc_wren;
  logic acc_wrdi;
  logic timer_done;

  assign aligned = (bit_cnt_q == BIT_ZERO);
  assign have_op = (byte_cnt_q >= BYTES_OPCODE);
  assign is_erase = (opcode_q == OP_SECTOR_ERASE) || (opcode_q == OP_BLOCK_ERASE) ||
                    (opcode_q == OP_CHIP_ERASE_A) || (opcode_q == OP_CHIP_ERASE_B);
  assign write_busy = (state_q == st_status_write) || array_busy;
  assign asleep = (state_q == st_sleep) || (state_q == st_enter_sleep) || (state_q == st_wake);
  assign locked = ~wp_n & lock_q;
  assign timer_done = (timer_q == '0);

  // a plain read (OP_READ) is never qualified here; the host keeps its clock low enough
  assign acc_wren = cs_rise && have_op && aligned && !asleep && opcode_q == OP_WRITE_ENABLE;
  assign acc_wrdi = cs_rise && have_op && aligned && !asleep && opcode_q == OP_WRITE_DISABLE;
  assign acc_status_write = cs_rise && aligned && !asleep && !write_busy && wel_q && !locked &&
                            opcode_q == OP_STATUS_WRITE &&
                            byte_cnt_q == BYTES_STATUS_WRITE;
  assign acc_program = cs_rise && aligned && !asleep && !write_busy && wel_q &&
                       opcode_q == OP_PAGE_PROGRAM &&
                       byte_cnt_q >= BYTES_PROGRAM_MIN;
  assign acc_erase = cs_rise && aligned && !asleep && !write_busy && wel_q && is_erase &&
                     byte_cnt_q == ((opcode_q == OP_CHIP_ERASE_A || opcode_q == OP_CHIP_ERASE_B) ?
                                    BYTES_OPCODE : BYTES_HEADER);
  assign acc_enter_sleep = cs_rise && have_op && aligned && !asleep && !write_busy &&
                           opcode_q == OP_DEEP_SLEEP;
  assign acc_wake = cs_rise && have_op && state_q == st_sleep && opcode_q == OP_WAKE;

  // ----------------------------------------------------------------
  // self-timed operations
  // ----------------------------------------------------------------
  logic [TIMER_W-1:0] status_write_load;

  assign status_write_load = fast_grade ? TIMER_W'(STATUS_WRITE_FAST - 1) :
                                          TIMER_W'(STATUS_WRITE_SLOW - 1);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= st_idle;
      timer_q <= '0;
    end else begin
      case (state_q)
        st_idle: begin
          if (acc_status_write) begin
            state_q <= st_status_write;
            timer_q <= status_write_load;
          end else if (acc_enter_sleep) begin
            state_q <= st_enter_sleep;
            timer_q <= TIMER_W'(DEEP_SLEEP_CYCLES - 1);
          end
        end
        st_status_write: begin
          if (timer_done) begin
            state_q <= st_idle;
          end else begin
            timer_q <= timer_q - 1'b1;
          end
        end
        st_enter_sleep: begin
          if (timer_done) begin
            state_q <= st_sleep;
          end else begin
            timer_q <= timer_q - 1'b1;
          end
        end
        st_sleep: begin
          if (acc_wake) begin
            state_q <= st_wake;
            timer_q <= TIMER_W'(WAKE_CYCLES - 1);
          end
        end
        st_wake: begin
          if (timer_done) begin
            state_q <= st_idle;
          end else begin
            timer_q <= timer_q - 1'b1;
          end
        end
        default: begin
          state_q <= st_idle;
          timer_q <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status contents
  // ----------------------------------------------------------------
  // new protection bits land only when the internal write finishes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prot_q <= PROT_RESET[3:0];
      lock_q <= LOCK_RESET;
    end else if (state_q == st_status_write && timer_done) begin
      prot_q <= {payload_q[SR_TB], payload_q[SR_BP_HI:SR_BP_LO]};
      lock_q <= payload_q[SR_LOCK];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wel_q <= 1'b0;
    end else if (acc_wren) begin
      wel_q <= 1'b1;
    end else if (acc_wrdi || acc_program || acc_erase || (state_q == st_status_write && timer_done)) begin
      wel_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_byte <= 8'h00;
    end else begin
      status_byte <= '0;
      status_byte[SR_BUSY] <= write_busy;
      status_byte[SR_WEL] <= wel_q;
      status_byte[SR_BP_HI:SR_BP_LO] <= prot_q[2:0];
      status_byte[SR_TB] <= prot_q[3];
      status_byte[SR_LOCK] <= lock_q;
    end
  end

  // ----------------------------------------------------------------
  // array hand-off and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      array_start <= 1'b0;
      array_opcode <= 8'h00;
      array_addr <= 24'h000000;
      cmd_rejected <= 1'b0;
    end else begin
      array_start <= acc_program || acc_erase;
      if (acc_program || acc_erase) begin
        array_opcode <= opcode_q;
        array_addr <= addr_q;
      end
      // only write-type and deep sleep frames report a refusal; reads and wake simply end
      cmd_rejected <= cs_rise && have_op && !(acc_status_write || acc_program || acc_erase ||
                      acc_enter_sleep || acc_wake || acc_wren || acc_wrdi) &&
                      (is_erase || opcode_q == OP_STATUS_WRITE || opcode_q == OP_PAGE_PROGRAM ||
                       opcode_q == OP_DEEP_SLEEP || opcode_q == OP_WRITE_ENABLE ||
                       opcode_q == OP_WRITE_DISABLE);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      deep_sleep <= 1'b0;
    end else begin
      deep_sleep <= (state_q == st_sleep);
    end
  end

  assign busy = write_busy || (state_q == st_enter_sleep);
  assign ready = (state_q == st_idle) || (state_q == st_status_write);

endmodule // sfg_command_guard

/* dv/sfg_host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// spi host driving the guard's serial pins
// ----------------------------------------
module sfg_host_model (
  input wire logic clock,
  output logic cs_n,
  output logic sck,
  output logic si
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // sck is 4 clocks a bit, 25 MHz, so even a plain read stays in range
  task automatic send(input logic [47:0] d, input int nb);
    @(posedge clock);
    #1 cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      @(posedge clock);
      #1 sck = 1'b0;
      si = d[47 - i];
      repeat (2) @(posedge clock);
      #1 sck = 1'b1;
      @(posedge clock);
    end
    @(posedge clock);
    #1 sck = 1'b0;
    @(posedge clock);
    #1 cs_n = 1'b1;
    // released line must not keep the last bit
    si = ~si;
    repeat (2) @(posedge clock);
  endtask
endmodule // sfg_host_model

/* dv/sfg_guard_chk.sv */
`timescale 1ns/1ps

// ----------------------------------------
// port checker for the command guard
// ----------------------------------------
module sfg_guard_chk #(
  parameter int STATUS_WRITE_SLOW = 50,
  parameter int STATUS_WRITE_FAST = 80
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic fast_grade,
  input wire logic array_busy,
  input wire logic busy,
  input wire logic ready,
  input wire logic [7:0] status_byte,
  input wire logic deep_sleep,
  input wire logic array_start,
  input wire logic cmd_rejected
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [31:0] sw_cnt_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      sw_cnt_q <= 32'h0;
    // count only the status write: array work and sleep entry also raise busy
    else if (busy && ready && !array_busy)
      sw_cnt_q <= sw_cnt_q + 32'h1;
    else
      sw_cnt_q <= 32'h0;
  end
  a_start_on_release: assert property (array_start |-> $past(cs_n) && !$past(cs_n, 2))
    else $error("array start not tied to select release");
  a_reject_on_release: assert property (cmd_rejected |-> $past(cs_n) && !$past(cs_n, 2))
    else $error("reject not tied to select release");
  a_start_one_cycle: assert property (array_start |=> !array_start)
    else $error("array start longer than one cycle");
  a_start_xor_reject: assert property (!(array_start && cmd_rejected))
    else $error("frame both started and rejected");
  a_write_time_bound: assert property (sw_cnt_q <= (fast_grade ? STATUS_WRITE_FAST : STATUS_WRITE_SLOW))
    else $error("status write runs too long");
  a_sleep_reached: assert property ($fell(ready) |-> ##[1:301] deep_sleep)
    else $error("deep sleep not reached in time");
  a_wake_ready: assert property ($fell(deep_sleep) |-> ##[1:300] ready)
    else $error("not ready in time after wake");
  a_sleep_not_ready: assert property (deep_sleep |-> !ready)
    else $error("ready while asleep");
  a_sleep_not_busy: assert property ($fell(ready) |-> !$past(busy))
    else $error("deep sleep taken while busy");
  a_busy_array: assert property (array_busy |-> busy)
    else $error("busy low during array work");
  a_busy_write: assert property ($rose(status_byte[0]) |-> busy [*4])
    else $error("busy dropped during status write");
  c_start: cover property (array_start);
  c_reject: cover property (cmd_rejected);
  c_sleep: cover property ($rose(deep_sleep));
  c_wake: cover property ($fell(deep_sleep));
endmodule // sfg_guard_chk

bind sfg_command_guard sfg_guard_chk #(.STATUS_WRITE_SLOW(STATUS_WRITE_SLOW), .STATUS_WRITE_FAST(STATUS_WRITE_FAST))
  u_chk (.clock(clock), .rst(rst), .cs_n(cs_n), .fast_grade(fast_grade), .array_busy(array_busy), .busy(busy),
  .ready(ready), .status_byte(status_byte), .deep_sleep(deep_sleep), .array_start(array_start),
  .cmd_rejected(cmd_rejected));

/* dv/tb_spi_flash_command_guard.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end

module tb_spi_flash_command_guard;
  import sfg_pkg::*;
  localparam int SLOW = 50;
  localparam int FAST = 80;
  logic clock, rst, wp_n, fast_grade, array_busy, cs_n, sck, si, cs_q;
  logic busy, ready, deep_sleep, array_start, cmd_rejected;
  logic [7:0] status_byte, array_opcode, keep;
  logic [23:0] array_addr;
  int n_errors, num_checks, cyc, t_rise, n_start, n_rej, n_busy;

  sfg_host_model u_host (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si));
  sfg_command_guard #(.STATUS_WRITE_SLOW(SLOW), .STATUS_WRITE_FAST(FAST)) DUT (.clock(clock), .rst(rst),
    .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .fast_grade(fast_grade), .array_busy(array_busy),
    .busy(busy), .ready(ready), .status_byte(status_byte), .deep_sleep(deep_sleep), .array_start(array_start),
    .array_opcode(array_opcode), .array_addr(array_addr), .cmd_rejected(cmd_rejected));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------
  // pulse counters and hang guard
  // ----------------------------------------
  always @(posedge clock) begin
    cyc++;
    if (array_start === 1'b1) n_start++;
    if (cmd_rejected === 1'b1) n_rej++;
    if (busy === 1'b1) n_busy++;
    if (cs_n === 1'b1 && cs_q === 1'b0) t_rise = cyc;
    cs_q = cs_n;
    if (cyc > 40000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic frame(input logic [47:0] d, input int nb);
    u_host.send(d, nb);
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic wen_clr();
    frame({OP_WRITE_ENABLE, 40'h0}, 8);
    n_start = 0;
    n_rej = 0;
    n_busy = 0;
  endtask

  // waits for the device to go idle, bounded
  task automatic settle();
    for (int i = 0; i < 400 && (busy !== 1'b0 || ready !== 1'b1); i++) begin
      @(posedge clock);
      #1;
    end
    // status byte lags the state by one register stage
    @(posedge clock);
    #1;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_off_byte();
    logic [7:0] ops [9];
    ops = '{OP_STATUS_WRITE, OP_PAGE_PROGRAM, OP_WRITE_DISABLE, OP_WRITE_ENABLE, OP_SECTOR_ERASE,
      OP_BLOCK_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_DEEP_SLEEP};
    foreach (ops[i]) begin
      wen_clr();
      frame({ops[i], 40'h0}, 9);
      `CHK("off_byte_rej", 1, n_rej)
      `CHK("off_byte_start", 0, n_start)
      `CHK("off_byte_ready", 1'b1, ready)
    end
    $display("test off_byte done");
  endtask

  task automatic t_program();
    wen_clr();
    frame({OP_PAGE_PROGRAM, 24'h0a1b2c, 8'h5a, 8'h0}, 40);
    `CHK("prog_start", 1, n_start)
    `CHK("prog_opcode", OP_PAGE_PROGRAM, array_opcode)
    `CHK("prog_addr", 24'h0a1b2c, array_addr)
    wen_clr();
    frame({OP_PAGE_PROGRAM, 24'h3d4e5f, 8'h5a, 8'h0}, 44);
    `CHK("part_rej", 1, n_rej)
    `CHK("part_start", 0, n_start)
    `CHK("part_addr", 24'h0a1b2c, array_addr)
    wen_clr();
    frame({OP_SECTOR_ERASE, 24'h123456, 16'h0}, 32);
    `CHK("erase_start", 1, n_start)
    `CHK("erase_opcode", OP_SECTOR_ERASE, array_opcode)
    `CHK("erase_addr", 24'h123456, array_addr)
    wen_clr();
    frame({OP_CHIP_ERASE_A, 40'h0}, 8);
    `CHK("chip_start", 1, n_start)
    `CHK("chip_opcode", OP_CHIP_ERASE_A, array_opcode)
    $display("test program done");
  endtask

  task automatic t_sw(input logic fg, input logic [7:0] pay, input logic ok);
    fast_grade = fg;
    wen_clr();
    keep = status_byte;
    frame({OP_STATUS_WRITE, pay, 32'h0}, 16);
    settle();
    `CHK("sw_busy_len", ok ? (fg ? FAST : SLOW) : 0, n_busy)
    `CHK("sw_rej", ok ? 0 : 1, n_rej)
    `CHK("sw_value", ok ? (pay & 8'hbc) : (keep & 8'hbc), status_byte & 8'hbc)
    $display("test status_write done");
  endtask

  task automatic t_sw_long();
    wen_clr();
    keep = status_byte;
    frame({OP_STATUS_WRITE, 8'h00, 8'h9c, 24'h0}, 24);
    settle();
    `CHK("long_rej", 1, n_rej)
    `CHK("long_busy", 0, n_busy)
    `CHK("long_value", keep, status_byte)
    $display("test status_long done");
  endtask

  // reset lands in the middle of a running status write
  task automatic t_reset();
    wen_clr();
    frame({OP_STATUS_WRITE, 8'h3c, 32'h0}, 16);
    `CHK("rst_pre_busy", 1'b1, busy)
    rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    `CHK("rst_status", 8'h00, status_byte)
    `CHK("rst_busy", 1'b0, busy)
    `CHK("rst_ready", 1'b1, ready)
    `CHK("rst_sleep", 1'b0, deep_sleep)
    $display("test reset done");
  endtask

  task automatic t_sleep();
    fast_grade = 1'b1;
    array_busy = 1'b1;
    wen_clr();
    frame({OP_DEEP_SLEEP, 40'h0}, 8);
    `CHK("busy_sleep_rej", 1, n_rej)
    `CHK("busy_sleep_ready", 1'b1, ready)
    array_busy = 1'b0;
    frame({OP_DEEP_SLEEP, 40'h0}, 8);
    for (int i = 0; i < 400 && deep_sleep !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    // one register stage between the sleep state and its output
    `CHK("sleep_lat", 1'b1, (cyc - t_rise) <= int'(DEEP_SLEEP_CYCLES) + 1)
    `CHK("sleep_ready", 1'b0, ready)
    frame({OP_WAKE, 40'h0}, 8);
    for (int i = 0; i < 400 && ready !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    `CHK("wake_lat", 1'b1, (cyc - t_rise) <= int'(WAKE_CYCLES))
    `CHK("wake_sleep", 1'b0, deep_sleep)
    $display("test sleep done");
  endtask

  initial begin
    n_errors = 0;
    num_checks = 0;
    cyc = 0;
    t_rise = 0;
    cs_q = 1'b1;
    rst = 1'b1;
    wp_n = 1'b1;
    fast_grade = 1'b0;
    array_busy = 1'b0;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    `CHK("reset_status", 8'h00, status_byte)
    t_off_byte();
    t_program();
    t_sw(1'b0, 8'h3c, 1'b1);
    t_sw(1'b1, 8'h1c, 1'b1);
    t_sw_long();
    t_sw(1'b0, 8'h80, 1'b1);
    wp_n = 1'b0;
    t_sw(1'b0, 8'h00, 1'b0);
    wp_n = 1'b1;
    t_reset();
    t_sw(1'b0, 8'h00, 1'b1);
    t_sleep();
    close_out();
  end
endmodule // tb_spi_flash_command_guard
